// file: logic/ape_pkg.sv
// Package for the ancillary packet extractor: map, fields, types
package ape_pkg;

   localparam int APE_DATA_W   = 32;
   localparam int APE_ADDR_W   = 13;
   localparam int APE_BANK_WDS = 1024;
   localparam int APE_TYPES    = 5;
   localparam int APE_LINE_W   = 11;

   // Register byte offsets
   localparam logic [12:0] APE_REG_CTRL  = 13'h0000;
   localparam logic [12:0] APE_REG_LINE  = 13'h0004;
   localparam logic [12:0] APE_REG_STAT  = 13'h0008;
   localparam logic [12:0] APE_REG_TYPE0 = 13'h0010;
   localparam logic [12:0] APE_REG_MEM   = 13'h1000;

   // Control bit positions
   localparam int APE_C_EXTDIS  = 0;
   localparam int APE_C_SWAP    = 1;
   localparam int APE_C_CONLY   = 2;
   localparam int APE_C_BOTH    = 3;
   localparam int APE_C_DELETE  = 4;
   localparam int APE_C_LINKB   = 5;

   localparam logic [9:0] APE_ADF0   = 10'h000;
   localparam logic [9:0] APE_ADF1   = 10'h3ff;
   localparam logic [9:0] APE_BLANK_Y = 10'h040;
   localparam logic [9:0] APE_BLANK_C = 10'h200;
   localparam logic [15:0] APE_ZERO16 = 16'h0000;

   typedef enum logic [1:0] {APE_SD, APE_HD, APE_3GA, APE_3GB} ape_mode_t;

   typedef enum {
      APE_IDLE, APE_F1, APE_F2, APE_DID, APE_SDID, APE_DC, APE_UDW
   } ape_pst_t;

   // Video word for one channel pair
   typedef struct packed {
      logic [9:0] y;
      logic [9:0] c;
   } ape_vid_t;

   typedef struct packed {
      logic       sof;     // Start of frame strobe
      logic       sol;     // Start of line strobe
      logic [10:0] line;
   } ape_tim_t;

endpackage : ape_pkg

// file: logic/ape_packet_extractor.sv
// Ancillary packet extractor: two-bank capture memory, filters, deletion
`timescale 1ns/10ps
module ape_packet_extractor
   import ape_pkg::*;
#(
   parameter int BANK_WORDS = APE_BANK_WDS
)(
   input  wire  logic               pclk,
   input  wire  logic               presetn,
   input  wire  logic               psel,
   input  wire  logic               penable,
   input  wire  logic               pwrite,
   input  wire  logic [12:0]        paddr,
   input  wire  logic [31:0]        pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   input  wire  ape_vid_t           vid_in,
   input  wire  ape_tim_t           vid_tim,
   input  wire  ape_mode_t          vid_mode,
   input  wire  logic               link_b_word,
   input  wire  logic               processing_enable_pin,
   input  wire  logic               lock_in,
   output ape_vid_t                 vid_out,
   output logic                     luma_packet_flag,
   output logic                     chroma_packet_flag
);

   localparam int AW = $clog2(BANK_WORDS);

   typedef struct packed {
      ape_pst_t   st;
      logic [9:0] cnt;
      logic [7:0] did;
      logic       hit;
      logic       del;
   } ape_ch_t;

   typedef struct packed {
      logic                  ready;
      logic [31:0]           rdata;
      logic                  err;
      logic [5:0]            ctrl;
      logic [21:0]           lines;
      logic [APE_TYPES*16-1:0] types;
      logic [1:0]            pin_s;
      logic [1:0]            lock_s;
      logic                  run;      // Extraction armed for this frame
      logic                  bank_b;   // Current write bank
      logic                  swap_prev;
      logic                  clr_a;
      logic [AW-1:0]         clr_ptr;
      logic [AW:0]           wptr;     // Write pointer in current bank
      logic [AW:0]           pkt_len;  // Words in current packet
      ape_ch_t               y;
      ape_ch_t               c;
      ape_vid_t              dly1;
      ape_vid_t              vout;
      logic                  fy;
      logic                  fc;
   } ape_st_t;

   ape_st_t s_q, s_d;

   logic [15:0] mem_a [BANK_WORDS];
   logic [15:0] mem_b [BANK_WORDS];
   logic        mem_we;
   logic        mem_wb;
   logic [AW-1:0] mem_wa;
   logic [15:0] mem_wd;

   // Per-channel lookahead: five delay stages (d0 to d4) let the flag word be held
   // until the type is known, at the cost of five words of video latency plus the output register
   ape_vid_t d0, d1, d2, d3, d4;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d0 <= '0;
         d1 <= '0;
         d2 <= '0;
         d3 <= '0;
         d4 <= '0;
      end else begin
         d0 <= vid_in;
         d1 <= d0;
         d2 <= d1;
         d3 <= d2;
         d4 <= d3;
      end
   end

   function automatic logic type_match(input logic [APE_TYPES*16-1:0] t,
                                       input logic [7:0] did,
                                       input logic [7:0] sdid);
      logic any;
      logic m;
      any = 1'b0;
      m = 1'b0;
      for (int i = 0; i < APE_TYPES; i++) begin
         if (t[i*16 +: 16] != APE_ZERO16) begin
            any = 1'b1;
            if (t[i*16+8 +: 8] == did &&
                (t[i*16 +: 8] == 8'h00 || t[i*16 +: 8] == sdid))
               m = 1'b1;
         end
      end
      return !any || m;
   endfunction : type_match

   // Packet tracker: flag word at d4, DID at d1, SDID at d0 after ADF
   function automatic ape_ch_t track(input ape_ch_t ch,
                                     input logic [9:0] w0,
                                     input logic [9:0] w1,
                                     input logic [9:0] w2,
                                     input logic [9:0] w3,
                                     input logic [APE_TYPES*16-1:0] t,
                                     input logic delen);
      ape_ch_t n;
      n = ch;
      case (ch.st)
         APE_IDLE: begin
            if (w3 == APE_ADF0 && w2 == APE_ADF1 && w1 == APE_ADF1)
               n.st = APE_F1;
         end
         APE_F1: begin
            n.st = APE_F2;
            n.did = w1[7:0];
            n.hit = type_match(t, w1[7:0], w0[7:0]);
            n.del = delen && n.hit;
         end
         APE_F2: begin
            // Count covers data count word through checksum
            n.st = APE_DID;
            n.cnt = {2'b00, w0[7:0]} + 10'h002;
         end
         APE_DID: n.st = APE_SDID;
         APE_SDID: n.st = APE_DC;
         APE_DC, APE_UDW: begin
            n.st = APE_UDW;
            n.cnt = ch.cnt - 10'h001;
            if (ch.cnt == 10'h000) begin
               n.st = APE_IDLE;
               n.del = 1'b0;
            end
         end
         default: n.st = APE_IDLE;
      endcase
      return n;
   endfunction : track

   logic        in_y, in_c, line_ok, want_y, want_c, sd;
   logic        acc, wr_acc, rd_acc;
   logic        hit_y, hit_c, del_y, del_c;
   logic [12:0] toff;

   always_comb begin
      s_d = s_q;
      mem_we = 1'b0;
      mem_wb = 1'b0;
      mem_wa = '0;
      mem_wd = '0;
      sd = (vid_mode == APE_SD);
      toff = paddr - APE_REG_TYPE0;
      acc = psel && penable && !s_q.ready;
      wr_acc = acc && pwrite;
      rd_acc = acc && !pwrite;

      s_d.pin_s = {s_q.pin_s[0], processing_enable_pin};
      s_d.lock_s = {s_q.lock_s[0], lock_in};

      // Register bus: one wait state, ready on the second access cycle
      s_d.ready = acc;
      s_d.err = 1'b0;
      if (wr_acc) begin
         case (paddr)
            APE_REG_CTRL: s_d.ctrl = pwdata[5:0];
            APE_REG_LINE: s_d.lines = pwdata[21:0];
            default: begin
               if (paddr >= APE_REG_TYPE0 &&
                   paddr < APE_REG_TYPE0 + 13'(4*APE_TYPES))
                  s_d.types[16*toff[4:2] +: 16] = pwdata[15:0];
               else
                  s_d.err = 1'b1;
            end
         endcase
      end
      if (rd_acc) begin
         s_d.rdata = '0;
         if (paddr >= APE_REG_MEM) begin
            if (!s_q.lock_s[1])
               s_d.err = 1'b1;
            else if (s_q.bank_b)
               s_d.rdata = {16'h0000, mem_b[paddr[AW+1:2]]};
            else
               s_d.rdata = {16'h0000, mem_a[paddr[AW+1:2]]};
         end else begin
            case (paddr)
               APE_REG_CTRL: s_d.rdata = {26'h0, s_q.ctrl};
               APE_REG_LINE: s_d.rdata = {10'h0, s_q.lines};
               APE_REG_STAT: s_d.rdata = {5'h0, s_q.clr_a, s_q.bank_b,
                                          s_q.run, 13'(s_q.wptr),
                                          s_q.fc, s_q.fy, 9'(s_q.pkt_len)};
               default: begin
                  if (paddr >= APE_REG_TYPE0 &&
                      paddr < APE_REG_TYPE0 + 13'(4*APE_TYPES))
                     s_d.rdata = {16'h0, s_q.types[16*toff[4:2] +: 16]};
                  else
                     s_d.err = 1'b1;
               end
            endcase
         end
      end

      if (s_q.ctrl[APE_C_EXTDIS] || !s_q.pin_s[1])
         s_d.run = 1'b0;
      else if (vid_tim.sof)
         s_d.run = 1'b1;

      in_y = !(vid_mode == APE_3GB && (link_b_word != s_q.ctrl[APE_C_LINKB]));
      want_y = in_y && (sd || s_q.ctrl[APE_C_BOTH] || !s_q.ctrl[APE_C_CONLY]);
      want_c = in_y && !sd && (s_q.ctrl[APE_C_BOTH] || s_q.ctrl[APE_C_CONLY]);
      in_c = want_c;

      line_ok = (s_q.lines[10:0] == 11'h000 && s_q.lines[21:11] == 11'h000)
                || (s_q.lines[10:0] != 11'h000 &&
                    s_q.lines[10:0] == vid_tim.line)
                || (s_q.lines[21:11] != 11'h000 &&
                    s_q.lines[21:11] == vid_tim.line);

      s_d.y = track(s_q.y, d0.y, d1.y, d2.y, d3.y, s_q.types,
                    s_q.ctrl[APE_C_DELETE] && s_q.pin_s[1]);
      s_d.c = track(s_q.c, d0.c, d1.c, d2.c, d3.c, s_q.types,
                    s_q.ctrl[APE_C_DELETE] && s_q.pin_s[1] && !sd);
      s_d.fy = (s_d.y.st != APE_IDLE) && want_y && s_q.pin_s[1];
      s_d.fc = (s_d.c.st != APE_IDLE) && want_c && s_q.pin_s[1];

      // Type first known in the flag word's own cycle
      hit_y = (s_q.y.st == APE_F1) ? s_d.y.hit : s_q.y.hit;
      hit_c = (s_q.c.st == APE_F1) ? s_d.c.hit : s_q.c.hit;
      del_y = s_q.y.del || (s_q.y.st == APE_F1 && s_d.y.del);
      del_c = s_q.c.del || (s_q.c.st == APE_F1 && s_d.c.del);

      // replace in place, word timing untouched
      s_d.vout = d4;
      if (del_y)
         s_d.vout.y = APE_BLANK_Y;
      if (del_c)
         s_d.vout.c = sd ? APE_BLANK_Y : APE_BLANK_C;

      if (s_q.y.st == APE_IDLE && s_q.c.st == APE_IDLE)
         s_d.pkt_len = '0;
      if (s_q.run && line_ok &&
          ((s_q.fy && hit_y) || (in_c && s_q.fc && hit_c)) &&
          s_q.wptr < (AW+1)'(BANK_WORDS) &&
          s_q.pkt_len <= (AW+1)'(BANK_WORDS)) begin
         mem_we = 1'b1;
         mem_wb = s_q.bank_b;
         mem_wa = s_q.wptr[AW-1:0];
         mem_wd[7:0] = (s_q.fy && hit_y) ? d4.y[7:0] : 8'h00;
         mem_wd[15:8] = (!sd && s_q.fc && hit_c) ? d4.c[7:0] : 8'h00;
         s_d.wptr = s_q.wptr + 1'b1;
         s_d.pkt_len = s_q.pkt_len + 1'b1;
      end

      s_d.swap_prev = s_q.ctrl[APE_C_SWAP];
      if (s_q.ctrl[APE_C_SWAP] != s_q.swap_prev && !s_q.ctrl[APE_C_EXTDIS]) begin
         s_d.wptr = '0;
         if (s_q.ctrl[APE_C_SWAP])
            s_d.bank_b = !s_q.bank_b;
         else if (s_q.bank_b) begin
            s_d.clr_a = 1'b1;
            s_d.clr_ptr = '0;
         end else begin
            s_d.bank_b = 1'b0;
         end
      end
      // Bank A clear steals the port only from A, B keeps filling
      if (s_q.clr_a) begin
         s_d.clr_ptr = s_q.clr_ptr + 1'b1;
         if (s_q.clr_ptr == AW'(BANK_WORDS - 1))
            s_d.clr_a = 1'b0;
      end
   end

   always_ff @(posedge pclk) begin
      if (mem_we && mem_wb)
         mem_b[mem_wa] <= mem_wd;
      if (mem_we && !mem_wb && !s_q.clr_a)
         mem_a[mem_wa] <= mem_wd;
      else if (s_q.clr_a)
         mem_a[s_q.clr_ptr] <= APE_ZERO16;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.ctrl[APE_C_EXTDIS] <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pready = s_q.ready;
   assign prdata = s_q.rdata;
   assign pslverr = s_q.err;
   assign vid_out = s_q.vout;
   assign luma_packet_flag = s_q.fy;
   assign chroma_packet_flag = s_q.fc;

   ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready)
      else $error("pready not raised one cycle into access");
   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held longer than one cycle");
   pin_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!processing_enable_pin)[*4] |-> !s_q.run && !s_q.y.del)
      else $error("extraction or delete active with pin low");
   sd_chroma_a: assert property (@(posedge pclk) disable iff (!presetn)
      (vid_mode == APE_SD) |=> !chroma_packet_flag)
      else $error("chroma flag raised in SD mode");
   sd_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mem_we && sd) |-> mem_wd[15:8] == 8'h00)
      else $error("upper byte written in SD mode");
   bank_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.wptr <= (AW+1)'(BANK_WORDS))
      else $error("write pointer past bank end");
   disable_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.ctrl[APE_C_EXTDIS] |=> !s_q.run)
      else $error("extraction armed while disabled");
   swap_b_a: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(s_q.ctrl[APE_C_SWAP]) && !s_q.ctrl[APE_C_EXTDIS] && !s_q.bank_b)
      |=> s_q.bank_b)
      else $error("swap high did not select bank B");
   clear_a_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_q.clr_a) |-> s_q.bank_b)
      else $error("bank A clear outside bank B use");
   del_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.y.del |=> vid_out.y == APE_BLANK_Y)
      else $error("deleted luma word not blanked");

endmodule : ape_packet_extractor

// file: verif/ape_host_model.sv
// Host model: APB master that programs and reads the extractor
`timescale 1ns/10ps
module ape_host_model
   import ape_pkg::*;
(
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [12:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   input  wire logic        lock_in,
   input  wire logic        luma_packet_flag,
   input  wire logic        chroma_packet_flag
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 13'h0000;
      pwdata  = 32'h00000000;
   end

   task automatic xfer(input logic w, input logic [12:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      // Bank swap only between packets
      if (w && a == APE_REG_CTRL)
         while (luma_packet_flag || chroma_packet_flag) @(posedge pclk);
      // Memory reads return an error while unlocked
      if (!w && a >= APE_REG_MEM)
         while (lock_in !== 1'b1) @(posedge pclk);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : ape_host_model

// file: verif/testbench.sv
// Self-checking bench for the ancillary packet extractor
`timescale 1ns/10ps
`define CHK(a, e) begin \
   n_checks++; \
   if ((a) !== (e)) begin \
      err_count++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, a, e); \
   end \
end
module testbench
   import ape_pkg::*;
;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [12:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   ape_vid_t    vid_in;
   ape_vid_t    vid_out;
   ape_tim_t    tim;
   ape_mode_t   mode;
   logic        link_b;
   logic        pin;
   logic        lock;
   logic        fly;
   logic        flc;
   logic [31:0] rq;
   logic        re;
   int          err_count;
   int          n_checks;
   int          fy;
   int          fc;
   int          nb;
   int          exp_wp;
   // Idle words that can never look like a flag or a blank
   localparam ape_vid_t IDLE = '{y: 10'h050, c: 10'h250};

   ape_packet_extractor dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .vid_in(vid_in),
      .vid_tim(tim), .vid_mode(mode), .link_b_word(link_b),
      .processing_enable_pin(pin), .lock_in(lock), .vid_out(vid_out),
      .luma_packet_flag(fly), .chroma_packet_flag(flc));
   ape_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .lock_in(lock),
      .luma_packet_flag(fly), .chroma_packet_flag(flc));

   always #20 pclk = ~pclk;

   always @(posedge pclk) begin
      if (fly === 1'b1) fy++;
      if (flc === 1'b1) fc++;
      if (vid_out.y === APE_BLANK_Y) nb++;
   end

   task automatic rd(input logic [12:0] a);
      host_u.xfer(1'b0, a, 32'h0, rq, re);
   endtask : rd

   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, rq, re);
   endtask : wr

   task automatic frame();
      @(posedge pclk);
      tim.sof <= 1'b1;
      @(posedge pclk);
      tim.sof <= 1'b0;
   endtask : frame

   task automatic pkt(input logic [7:0] did, input logic [7:0] sdid,
                      input int dc, input logic [10:0] ln,
                      input logic ony, input logic onc);
      logic [9:0] w;
      fy = 0;
      fc = 0;
      nb = 0;
      for (int i = 0; i < dc + 7; i++) begin
         w = i == 0 ? APE_ADF0 : i < 3 ? APE_ADF1 : i == 3 ? {2'b10, did} :
             i == 4 ? {2'b10, sdid} : i == 5 ? 10'(dc) : 10'h100 + 10'(i);
         @(posedge pclk);
         vid_in.y <= ony ? w : IDLE.y;
         vid_in.c <= onc ? w : IDLE.c;
         tim.line <= ln;
      end
      @(posedge pclk);
      vid_in <= IDLE;
      repeat (20) @(posedge pclk);
   endtask : pkt

   // Write pointer moves one per captured word; checked after every packet except the delete test
   task automatic wp(input int grow);
      exp_wp += grow;
      rd(APE_REG_STAT);
      `CHK(rq[23:11], exp_wp[12:0])
   endtask : wp

   task automatic close_out();
      if (err_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   initial begin
      repeat (10000) @(posedge pclk);
      err_count++;
      close_out();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      vid_in = IDLE;
      tim = '0;
      mode = APE_HD;
      link_b = 1'b0;
      pin = 1'b1;
      lock = 1'b1;
      err_count = 0;
      n_checks = 0;
      exp_wp = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(APE_REG_CTRL);
      `CHK(rq, 32'h00000000)
      rd(13'h0ffc);
      `CHK(re, 1'b1)
      frame();
      pkt(8'h41, 8'h05, 2, 11'd9, 1'b1, 1'b0);
      `CHK(fy, 9)
      `CHK(fc, 0)
      wp(9);
      rd(APE_REG_MEM + 13'd12);
      `CHK(rq[7:0], 8'h41)
      rd(APE_REG_MEM + 13'd20);
      `CHK(rq[7:0], 8'h02)
      wr(APE_REG_CTRL, 32'h4);
      pkt(8'h41, 8'h05, 1, 11'd9, 1'b0, 1'b1);
      `CHK(fc, 8)
      `CHK(fy, 0)
      wp(8);
      rd(APE_REG_MEM + 13'd48);
      `CHK(rq[15:8], 8'h41)
      wr(APE_REG_CTRL, 32'hc);
      pkt(8'h41, 8'h05, 1, 11'd9, 1'b1, 1'b1);
      `CHK(fy + fc, 16)
      wp(8);
      mode <= APE_SD;
      pkt(8'h41, 8'h05, 1, 11'd9, 1'b1, 1'b1);
      `CHK(fc, 0)
      wp(8);
      rd(APE_REG_MEM + 13'd112);
      `CHK(rq[15:0], 16'h0041)
      mode <= APE_HD;
      wr(APE_REG_CTRL, 32'h0);
      wr(APE_REG_TYPE0, 32'h4105);
      pkt(8'h42, 8'h05, 1, 11'd9, 1'b1, 1'b0);
      wp(0);
      pkt(8'h41, 8'h05, 1, 11'd9, 1'b1, 1'b0);
      wp(8);
      wr(APE_REG_TYPE0, 32'h0);
      wr(APE_REG_LINE, 32'h5);
      pkt(8'h41, 8'h05, 1, 11'd3, 1'b1, 1'b0);
      wp(0);
      pkt(8'h41, 8'h05, 1, 11'd5, 1'b1, 1'b0);
      wp(8);
      wr(APE_REG_LINE, 32'h0);
      pin <= 1'b0;
      repeat (4) @(posedge pclk);
      pkt(8'h41, 8'h05, 1, 11'd9, 1'b1, 1'b0);
      `CHK(fy, 0)
      wp(0);
      pin <= 1'b1;
      wr(APE_REG_CTRL, 32'h1);
      pkt(8'h41, 8'h05, 1, 11'd9, 1'b1, 1'b0);
      wp(0);
      wr(APE_REG_CTRL, 32'h0);
      pkt(8'h41, 8'h05, 1, 11'd9, 1'b1, 1'b0);
      wp(0);
      frame();
      pkt(8'h41, 8'h05, 1, 11'd9, 1'b1, 1'b0);
      wp(8);
      wr(APE_REG_CTRL, 32'h10);
      pkt(8'h41, 8'h05, 2, 11'd9, 1'b1, 1'b0);
      `CHK(nb, 9)
      wr(APE_REG_CTRL, 32'h2);
      rd(APE_REG_STAT);
      `CHK(rq[25], 1'b1)
      wr(APE_REG_CTRL, 32'h0);
      rd(APE_REG_STAT);
      `CHK(rq[26:25], 2'b11)
      wr(APE_REG_CTRL, 32'h2);
      rd(APE_REG_STAT);
      `CHK(rq[25], 1'b0)
      close_out();
   end
endmodule : testbench
